// ### sbra_top.sv
// Purpose: indirect register access to three serial ports and the dma controller
// Assumes: single-cycle read and write strobes from the core, 16-bit data
// Notes: read data is registered and appears one cycle after the strobe
`timescale 1ns/1ps
`include "sbra_regs.svh"

module sbra_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire sbra_pkg::sbra_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic hit
);

    // ************************************************************
    // decode helpers
    // ************************************************************
    // serial subaddress to storage index, -1 when unassigned
    function automatic logic [5:0] sp_index(input logic [5:0] sa);
        if (sa <= `SBRA_SP_BASE_LAST) begin
            sp_index = sa;
        end else if (sa >= `SBRA_SP_EXT_FIRST && sa <= `SBRA_SP_EXT_LAST) begin
            sp_index = sa - 6'h01;
        end else begin
            sp_index = 6'h3f;
        end
    endfunction

    // dma subaddress valid: channel words 00h-1Dh and shared page 1Eh
    function automatic logic dma_valid(input logic [5:0] sa);
        dma_valid = (sa <= `SBRA_DMA_SRC_PAGE);
    endfunction

    function automatic sbra_pkg::sbra_tgt_t data_tgt(input logic [15:0] a);
        case (a)
            `SBRA_ADDR_SP0_DATA: data_tgt = sbra_pkg::SBRA_TGT_SP0;
            `SBRA_ADDR_SP1_DATA: data_tgt = sbra_pkg::SBRA_TGT_SP1;
            `SBRA_ADDR_SP2_DATA: data_tgt = sbra_pkg::SBRA_TGT_SP2;
            `SBRA_ADDR_DMA_AUTOINC, `SBRA_ADDR_DMA_PLAIN: data_tgt = sbra_pkg::SBRA_TGT_DMA;
            default: data_tgt = sbra_pkg::SBRA_TGT_NONE;
        endcase
    endfunction

    // ************************************************************
    // storage
    // ************************************************************
    logic [15:0] sp_mem_q [3][`SBRA_SP_WORDS];
    logic [15:0] dma_mem_q [`SBRA_DMA_WORDS];
    logic [5:0] sp_ptr_q [3];
    logic [5:0] sp_ptr_d [3];
    logic [5:0] dma_ptr_q;
    logic [5:0] dma_ptr_d;
    logic [15:0] prec_q;
    logic [15:0] prec_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    sbra_pkg::sbra_tgt_t tgt;
    logic [1:0] sp_sel;
    logic [5:0] sp_idx;
    logic sp_ok;
    logic dma_ok;
    logic acc;
    logic wr_sp;
    logic wr_dma;

    // decode of the current request
    always_comb begin
        tgt = data_tgt(req.addr);
        sp_sel = (tgt == sbra_pkg::SBRA_TGT_SP1) ? 2'd1 :
                 (tgt == sbra_pkg::SBRA_TGT_SP2) ? 2'd2 : 2'd0;
        sp_idx = sp_index(sp_ptr_q[sp_sel]);
        sp_ok = (sp_idx != 6'h3f);
        dma_ok = dma_valid(dma_ptr_q);
        acc = req.rd | req.wr;
        wr_sp = req.wr && sp_ok && (tgt inside {sbra_pkg::SBRA_TGT_SP0, sbra_pkg::SBRA_TGT_SP1,
                                                sbra_pkg::SBRA_TGT_SP2});
        wr_dma = req.wr && dma_ok && (tgt == sbra_pkg::SBRA_TGT_DMA);
    end

    // ************************************************************
    // pointers, direct register and read path
    // ************************************************************
    always_comb begin
        sp_ptr_d = sp_ptr_q;
        dma_ptr_d = dma_ptr_q;
        prec_d = prec_q;
        rdata_d = rdata_q;
        rvalid_d = req.rd;
        // pointer writes; 6 low bits cover every subaddress
        if (req.wr) begin
            case (req.addr)
                `SBRA_ADDR_SP0_PTR: sp_ptr_d[0] = req.wdata[5:0];
                `SBRA_ADDR_SP1_PTR: sp_ptr_d[1] = req.wdata[5:0];
                `SBRA_ADDR_SP2_PTR: sp_ptr_d[2] = req.wdata[5:0];
                `SBRA_ADDR_DMA_PTR: dma_ptr_d = req.wdata[5:0];
                `SBRA_ADDR_DMA_PREC: prec_d = req.wdata;
                default: ;
            endcase
        end
        // postincrement on any access, also out-of-range ones
        if (acc && req.addr == `SBRA_ADDR_DMA_AUTOINC) begin
            dma_ptr_d = dma_ptr_q + 6'h01;
        end
        if (req.rd) begin
            case (req.addr)
                `SBRA_ADDR_SP0_PTR: rdata_d = {10'h000, sp_ptr_q[0]};
                `SBRA_ADDR_SP1_PTR: rdata_d = {10'h000, sp_ptr_q[1]};
                `SBRA_ADDR_SP2_PTR: rdata_d = {10'h000, sp_ptr_q[2]};
                `SBRA_ADDR_DMA_PTR: rdata_d = {10'h000, dma_ptr_q};
                `SBRA_ADDR_DMA_PREC: rdata_d = prec_q;
                default: begin
                    if (tgt == sbra_pkg::SBRA_TGT_DMA) begin
                        rdata_d = dma_ok ? dma_mem_q[dma_ptr_q[4:0]] : `SBRA_RESET_WORD;
                    end else if (tgt != sbra_pkg::SBRA_TGT_NONE) begin
                        rdata_d = sp_ok ? sp_mem_q[sp_sel][sp_idx[4:0]] : `SBRA_RESET_WORD;
                    end else begin
                        rdata_d = `SBRA_RESET_WORD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int p = 0; p < 3; p++) begin
                sp_ptr_q[p] <= `SBRA_RESET_PTR;
            end
            dma_ptr_q <= `SBRA_RESET_PTR;
            prec_q <= `SBRA_RESET_WORD;
            rdata_q <= `SBRA_RESET_WORD;
            rvalid_q <= 1'b0;
        end else if (clk_en) begin
            sp_ptr_q <= sp_ptr_d;
            dma_ptr_q <= dma_ptr_d;
            prec_q <= prec_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ************************************************************
    // subbank storage writes
    // ************************************************************
    // write enables come from the decode; arrays reset to zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int p = 0; p < 3; p++) begin
                for (int i = 0; i < `SBRA_SP_WORDS; i++) begin
                    sp_mem_q[p][i] <= `SBRA_RESET_WORD;
                end
            end
            for (int i = 0; i < `SBRA_DMA_WORDS; i++) begin
                dma_mem_q[i] <= `SBRA_RESET_WORD;
            end
        end else if (clk_en) begin
            if (wr_sp) begin
                sp_mem_q[sp_sel][sp_idx[4:0]] <= req.wdata;
            end
            if (wr_dma) begin
                dma_mem_q[dma_ptr_q[4:0]] <= req.wdata;
            end
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign hit = acc && ((tgt != sbra_pkg::SBRA_TGT_NONE) || req.addr == `SBRA_ADDR_DMA_PTR ||
                 req.addr == `SBRA_ADDR_DMA_PREC || req.addr == `SBRA_ADDR_SP0_PTR ||
                 req.addr == `SBRA_ADDR_SP1_PTR || req.addr == `SBRA_ADDR_SP2_PTR);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    autoinc_step_a: assert property (clk_en && acc && req.addr == `SBRA_ADDR_DMA_AUTOINC &&
        !(req.wr && req.addr == `SBRA_ADDR_DMA_PTR) |=> dma_ptr_q == $past(dma_ptr_q) + 6'h01)
        else $error("dma pointer did not advance");
    plain_hold_a: assert property (clk_en && acc && req.addr == `SBRA_ADDR_DMA_PLAIN
        |=> dma_ptr_q == $past(dma_ptr_q))
        else $error("plain port moved dma pointer");
    dma_ptr_a: assert property (clk_en && req.wr && req.addr == `SBRA_ADDR_DMA_PTR
        |=> dma_ptr_q == $past(req.wdata[5:0]))
        else $error("dma pointer write lost");
    sp_ptr_a: assert property (clk_en && req.wr && req.addr == `SBRA_ADDR_SP1_PTR
        |=> sp_ptr_q[1] == $past(req.wdata[5:0]))
        else $error("serial pointer write lost");
    prec_write_a: assert property (clk_en && req.wr && req.addr == `SBRA_ADDR_DMA_PREC
        |=> prec_q == $past(req.wdata))
        else $error("priority register write lost");
    sp_gap_a: assert property (clk_en && req.rd && tgt == sbra_pkg::SBRA_TGT_SP0 &&
        sp_ptr_q[0] == 6'h0f |=> rvalid && rdata == 16'h0000)
        else $error("unassigned serial subaddress read nonzero");
    dma_gap_a: assert property (clk_en && req.rd && tgt == sbra_pkg::SBRA_TGT_DMA &&
        dma_ptr_q > `SBRA_DMA_SRC_PAGE |=> rdata == 16'h0000)
        else $error("dma subaddress beyond 1Eh read nonzero");
    sp_rdback_a: assert property (clk_en && wr_sp && sp_sel == 2'd2 && sp_idx == 6'h0e
        |=> sp_mem_q[2][14] == $past(req.wdata))
        else $error("pin control write lost");
    dma_rdback_a: assert property (clk_en && wr_dma && dma_ptr_q == 6'h1d
        |=> dma_mem_q[29] == $past(req.wdata))
        else $error("last channel word write lost");
    ext_map_a: assert property (clk_en && wr_sp && sp_sel == 2'd0 && sp_ptr_q[0] == 6'h10
        |=> sp_mem_q[0][15] == $past(req.wdata))
        else $error("extended channel register write lost");
    rvalid_a: assert property (clk_en && req.rd |=> rvalid)
        else $error("read answer missing");

    autoinc_run_c: cover property (clk_en && req.wr && req.addr == `SBRA_ADDR_DMA_AUTOINC ##1
        clk_en && req.wr && req.addr == `SBRA_ADDR_DMA_AUTOINC);
    sp_read_c: cover property (clk_en && req.rd && tgt == sbra_pkg::SBRA_TGT_SP2 && sp_ok);
    gap_write_c: cover property (clk_en && req.wr && tgt == sbra_pkg::SBRA_TGT_SP1 && !sp_ok);

endmodule // sbra_top

// ### sbra_regs.svh
// Purpose: offsets, field sizes and reset values of the subbank register access block
// Assumes: 16-bit data-memory bus, word addresses
// Notes: every address, subaddress bound and reset value of the block lives here as a macro
`ifndef SBRA_REGS_SVH
`define SBRA_REGS_SVH

// ************************************************************
// direct data-memory addresses
// ************************************************************
`define SBRA_ADDR_SP2_PTR 16'h0034
`define SBRA_ADDR_SP2_DATA 16'h0035
`define SBRA_ADDR_SP0_PTR 16'h0038
`define SBRA_ADDR_SP0_DATA 16'h0039
`define SBRA_ADDR_SP1_PTR 16'h0048
`define SBRA_ADDR_SP1_DATA 16'h0049
`define SBRA_ADDR_DMA_PREC 16'h0054
`define SBRA_ADDR_DMA_PTR 16'h0055
`define SBRA_ADDR_DMA_AUTOINC 16'h0056
`define SBRA_ADDR_DMA_PLAIN 16'h0057

// ************************************************************
// subaddress layout
// ************************************************************
`define SBRA_SP_BASE_LAST 6'h0e
`define SBRA_SP_EXT_FIRST 6'h10
`define SBRA_SP_EXT_LAST 6'h1b
`define SBRA_SP_WORDS 28
`define SBRA_DMA_CH_WORDS 5
`define SBRA_DMA_CHANNELS 6
`define SBRA_DMA_CH_LAST 6'h1d
`define SBRA_DMA_SRC_PAGE 6'h1e
`define SBRA_DMA_WORDS 31
`define SBRA_RESET_WORD 16'h0000
`define SBRA_RESET_PTR 6'h00

`endif

// ### sbra_pkg.sv
// Purpose: types shared by the subbank register access block
// Assumes: nothing beyond the register header
// Notes: the bus request travels as one packed struct
package sbra_pkg;
    // one data-memory request from the processor
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sbra_req_t;

    // which subbank a direct address reaches
    typedef enum logic [2:0] {
        SBRA_TGT_NONE,
        SBRA_TGT_SP0,
        SBRA_TGT_SP1,
        SBRA_TGT_SP2,
        SBRA_TGT_DMA
    } sbra_tgt_t;
endpackage

// ### sbra_core_bfm.sv
// Purpose: core-side model of the data-memory bus that drives the subbank block
// Assumes: one-cycle rd/wr strobes, read answer registered at the taking edge and sampled 1 ns after it
// Notes: idle after an access, the address and data lines show the inverse of the last value; before the first access they are zero
`timescale 1ns/1ps

module sbra_core_bfm (
    input wire logic clk,
    output sbra_pkg::sbra_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic hit
);
    // ************************************************************
    // bus idle at time zero
    // ************************************************************
    initial begin
        req = '0;
    end

    // one access: raise after an edge, hold to the taking edge, then release
    task automatic access(input logic is_rd, input logic [15:0] addr, input logic [15:0] wdata,
        output logic [15:0] data, output logic seen_hit, output logic seen_valid);
        @(posedge clk);
        req <= '{rd: is_rd, wr: !is_rd, addr: addr, wdata: wdata};
        #1 seen_hit = hit;
        @(posedge clk);
        // released lines must not keep a value a sloppy decoder could still use
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        #1 data = rdata;
        seen_valid = rvalid;
    endtask
endmodule // sbra_core_bfm

// ### tb_top.sv
// Purpose: self-checking bench for the subbank register access block
// Assumes: core bus model in sbra_core_bfm, reset held three cycles
// Notes: every subaddress 00h-1Fh of every subbank is written, then read back
`timescale 1ns/1ps
`include "sbra_regs.svh"

module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    sbra_pkg::sbra_req_t req;
    logic [15:0] rdata;
    logic rvalid;
    logic hit;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [15:0] sp_ptr [3] = '{`SBRA_ADDR_SP0_PTR, `SBRA_ADDR_SP1_PTR, `SBRA_ADDR_SP2_PTR};
    logic [15:0] sp_dat [3] = '{`SBRA_ADDR_SP0_DATA, `SBRA_ADDR_SP1_DATA, `SBRA_ADDR_SP2_DATA};

    // ************************************************************
    // clock, design and core model
    // ************************************************************
    always #2.5 clk = ~clk;

    sbra_top DUT (.clk(clk), .nrst(nrst), .clk_en(clk_en), .req(req), .rdata(rdata),
        .rvalid(rvalid), .hit(hit));
    sbra_core_bfm core (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid), .hit(hit));

    // ************************************************************
    // comparison, access and closing tasks
    // ************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // a write ignores val as expectation; a read compares rvalid and rdata
    task automatic go(input logic is_rd, input logic [15:0] addr, input logic [15:0] val,
        input logic exp_hit = 1'b1);
        logic [15:0] d;
        logic h;
        logic v;
        core.access(is_rd, addr, val, d, h, v);
        check("hit", {15'h0000, h}, {15'h0000, exp_hit});
        // a write must not leave a read answer behind
        check("rvalid", {15'h0000, v}, {15'h0000, is_rd});
        if (is_rd) begin
            check("rdata", d, val);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // distinct word per subbank and subaddress, so a wrong decode shows
    function automatic logic [15:0] pat(input logic [1:0] p, input logic [5:0] s);
        return {2'b10, p, 6'h15, s};
    endfunction

    function automatic logic sp_ok(input logic [5:0] s);
        return s <= `SBRA_SP_BASE_LAST || (s >= `SBRA_SP_EXT_FIRST && s <= `SBRA_SP_EXT_LAST);
    endfunction

    // ************************************************************
    // watchdog and main sequence
    // ************************************************************
    // a stuck sequence ends the run as a failure, never as a pass
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("BAD watchdog expected done seen timeout");
        complete_run();
    end

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        // pointers and words start at zero
        for (int p = 0; p < 3; p++) begin
            go(1'b1, sp_ptr[p], 16'h0000);
            go(1'b1, sp_dat[p], 16'h0000);
        end
        go(1'b1, `SBRA_ADDR_DMA_PTR, 16'h0000);
        // fill all three serial subbanks, upper pointer bits must drop
        for (int p = 0; p < 3; p++) begin
            for (int s = 0; s < 32; s++) begin
                go(1'b0, sp_ptr[p], {10'h3ff, 6'(s)});
                go(1'b1, sp_ptr[p], {10'h000, 6'(s)});
                go(1'b0, sp_dat[p], pat(2'(p), 6'(s)));
            end
        end
        // read back after all writes: ports stay apart, gaps read zero
        for (int p = 0; p < 3; p++) begin
            for (int s = 0; s < 32; s++) begin
                go(1'b0, sp_ptr[p], {10'h000, 6'(s)});
                go(1'b1, sp_dat[p], sp_ok(6'(s)) ? pat(2'(p), 6'(s)) : 16'h0000);
            end
        end
        // dma subbank filled through the autoincrement port
        go(1'b0, `SBRA_ADDR_DMA_PTR, 16'h0000);
        for (int s = 0; s < 32; s++) begin
            go(1'b0, `SBRA_ADDR_DMA_AUTOINC, pat(2'd3, 6'(s)));
        end
        go(1'b1, `SBRA_ADDR_DMA_PTR, 16'h0020);
        // plain port reads keep the pointer where software put it
        for (int s = 0; s < 32; s++) begin
            go(1'b0, `SBRA_ADDR_DMA_PTR, {10'h000, 6'(s)});
            go(1'b1, `SBRA_ADDR_DMA_PLAIN, (s < 31) ? pat(2'd3, 6'(s)) : 16'h0000);
            go(1'b1, `SBRA_ADDR_DMA_PTR, {10'h000, 6'(s)});
        end
        // autoincrement on reads, then the 6-bit wrap
        go(1'b0, `SBRA_ADDR_DMA_PTR, 16'h0000);
        for (int s = 0; s < 31; s++) begin
            go(1'b1, `SBRA_ADDR_DMA_AUTOINC, pat(2'd3, 6'(s)));
        end
        go(1'b1, `SBRA_ADDR_DMA_PTR, 16'h001f);
        go(1'b0, `SBRA_ADDR_DMA_PTR, 16'h003f);
        go(1'b1, `SBRA_ADDR_DMA_AUTOINC, 16'h0000);
        go(1'b1, `SBRA_ADDR_DMA_PTR, 16'h0000);
        // priority register is direct storage; neighbours are not decoded
        go(1'b0, `SBRA_ADDR_DMA_PREC, 16'ha5c3);
        go(1'b1, `SBRA_ADDR_DMA_PREC, 16'ha5c3);
        go(1'b1, 16'h0058, 16'h0000, 1'b0);
        go(1'b0, 16'h0036, 16'hffff, 1'b0);
        go(1'b1, `SBRA_ADDR_SP2_DATA, 16'h0000);
        // clock enable low: a pointer write presented then is not taken
        go(1'b0, sp_ptr[0], 16'h0005);
        @(posedge clk);
        clk_en <= 1'b0;
        go(1'b0, sp_ptr[0], 16'h0009);
        @(posedge clk);
        clk_en <= 1'b1;
        go(1'b1, sp_ptr[0], 16'h0005);
        // mid-run reset clears pointers, subbank words and the direct register
        go(1'b0, sp_dat[0], 16'h1234);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        go(1'b1, sp_ptr[0], 16'h0000);
        go(1'b1, `SBRA_ADDR_DMA_PREC, 16'h0000);
        go(1'b0, sp_ptr[0], 16'h0005);
        go(1'b1, sp_dat[0], 16'h0000);
        complete_run();
    end
endmodule // tb_top
